// ---- hw/gpm_pkg.sv ----
// package: encodings, reset values and widths for the eight-pin port
package gpm_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned FUNC_W    = 4;

  // interrupt sensing choice per pin
  typedef enum logic [2:0] {
    SENSE_FALLING = 3'h0,
    SENSE_RISING  = 3'h1,
    SENSE_BOTH    = 3'h2,
    SENSE_LOW     = 3'h3,
    SENSE_HIGH    = 3'h4
  } gpm_sense_type;

  // output drive strength
  typedef enum logic [1:0] {
    DRIVE_TWO_MILLIAMP          = 2'h0,
    DRIVE_FOUR_MILLIAMP         = 2'h1,
    DRIVE_EIGHT_MILLIAMP        = 2'h2,
    DRIVE_EIGHT_MILLIAMP_SLEWED = 2'h3
  } gpm_drive_type;

  // pad type
  typedef enum logic [2:0] {
    PAD_PUSH_PULL           = 3'h0,
    PAD_PUSH_PULL_PULLUP    = 3'h1,
    PAD_PUSH_PULL_PULLDOWN  = 3'h2,
    PAD_OPEN_DRAIN          = 3'h3,
    PAD_OPEN_DRAIN_PULLUP   = 3'h4,
    PAD_OPEN_DRAIN_PULLDOWN = 3'h5,
    PAD_ANALOG              = 3'h6
  } gpm_pad_type;

  // pin direction and ownership
  typedef enum logic [1:0] {
    DIR_SW_INPUT         = 2'h0,
    DIR_SW_OUTPUT        = 2'h1,
    DIR_PERIPHERAL_OWNED = 2'h2
  } gpm_dir_type;

  // reset values
  localparam gpm_sense_type SENSE_RESET = SENSE_FALLING;
  localparam gpm_drive_type DRIVE_RESET = DRIVE_TWO_MILLIAMP;
  localparam gpm_pad_type   PAD_RESET   = PAD_PUSH_PULL;
  localparam gpm_dir_type   DIR_RESET   = DIR_SW_INPUT;
  localparam logic [3:0]    FUNC_NONE   = 4'h0;
  localparam logic [7:0]    MASK_RESET  = 8'h00;
endpackage : gpm_pkg

// ---- hw/gpm_sense_if.sv ----
// interface: per-pin sensing settings and event results between top and detector
`timescale 1ns/1ns
interface gpm_sense_if;
  import gpm_pkg::*;
  gpm_sense_type sense [PIN_COUNT];  // sensing choice per pin
  logic [7:0]    level;              // synchronised pin levels
  logic [7:0]    hit;                // one-cycle edge hit or active level
  logic [7:0]    is_level;           // pin is level sensed
  modport ctrl (output sense, output level, input hit, input is_level);
  modport det  (input sense, input level, output hit, output is_level);
endinterface : gpm_sense_if

// ---- hw/gpm_edge_detect.sv ----
// per-pin edge and level detector for the port interrupt logic
`timescale 1ns/1ns
module gpm_edge_detect
  import gpm_pkg::*;
(
  input wire logic clk,       // system clock
  input wire logic reset_n,   // synchronous reset, active low
  gpm_sense_if.det sif        // settings in, hits out
);
  logic [7:0] prev_q;

  // previous level for edge compare; resets like the synchroniser, and with falling sense as the
  // reset default neither idle level of a pin reads as an event once reset ends
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prev_q <= 8'h00;
    else
      prev_q <= sif.level;
  end

  // one detector per pin
  genvar gi;
  for (gi = 0; gi < PIN_COUNT; gi++)
  begin : g_pin
    always_comb
    begin
      sif.hit[gi]      = 1'b0;
      sif.is_level[gi] = 1'b0;
      case (sif.sense[gi])
        SENSE_FALLING: sif.hit[gi] = prev_q[gi] & ~sif.level[gi];
        SENSE_RISING:  sif.hit[gi] = ~prev_q[gi] & sif.level[gi];
        SENSE_BOTH:    sif.hit[gi] = prev_q[gi] ^ sif.level[gi];
        SENSE_LOW:
        begin
          sif.hit[gi]      = ~sif.level[gi];
          sif.is_level[gi] = 1'b1;
        end
        SENSE_HIGH:
        begin
          sif.hit[gi]      = sif.level[gi];
          sif.is_level[gi] = 1'b1;
        end
        default:       sif.hit[gi] = 1'b0;
      endcase
    end
  end
endmodule : gpm_edge_detect

// ---- hw/gpm_port.sv ----
// eight-pin port: interrupt sensing, pad configuration, pin mux and pin data
// Functional notes
// - five sensing choices per pin
// - drive 2, 4, 8 mA or 8 mA slewed
// - push-pull or open-drain per pin
// - weak pull-up or pull-down with either type
// - analog type disconnects digital output drive; input still synchronised and sensed
// - input pins: only pulls and analog mode take effect
// - pad readback returns stored values
// - at most one function per pin
// - clear removes pending selected pins only
// - disable masks selected pins
// - enable unmasks selected pins
// - raw and masked status views
// - status bit n is pin n, upper zero
// - eight-bit mask selects pins
// - pins input, output or peripheral owned
// - masked read zeroes unselected pins
`timescale 1ns/1ns
module gpm_port
  import gpm_pkg::*;
#(
  parameter int unsigned FUNCS = 16  // peripheral functions offered on the mux
)
(
  input  wire logic          clk,              // 10 MHz system clock
  input  wire logic          reset_n,          // synchronous reset, active low
  input  wire logic [7:0]    pin_select_mask,  // pins selected by any command
  input  wire logic          set_sense,        // pulse: load sense_value
  input  wire gpm_sense_type sense_value,      // sensing choice to load
  input  wire logic          set_pad,          // pulse: load drive and pad type
  input  wire gpm_drive_type drive_value,      // drive strength to load
  input  wire gpm_pad_type   pad_value,        // pad type to load
  input  wire logic          set_dir,          // pulse: load direction
  input  wire gpm_dir_type   dir_value,        // direction to load
  input  wire logic          set_func,         // pulse: attach func_value to pins
  input  wire logic [3:0]    func_value,       // function number, 0 none
  input  wire logic          write_data,       // pulse: write out_value to pins
  input  wire logic [7:0]    out_value,        // software output data
  input  wire logic          int_clear,        // pulse: clear pending
  input  wire logic          int_disable,      // pulse: mask selected
  input  wire logic          int_enable,       // pulse: unmask selected
  input  wire logic          status_view_select, // 1 masked, 0 raw
  input  wire logic [2:0]    query_pin,        // pin for config readback
  input  wire logic [FUNCS-1:0] periph_out,    // function output data
  input  wire logic [FUNCS-1:0] periph_oe,     // function output enable
  input  wire logic [7:0]    pin_in,           // pad input levels, async
  output logic [7:0]         pin_out,          // pad output data
  output logic [7:0]         pin_oe,           // pad output enable, high drives
  output logic [7:0]         pin_pullup,       // weak pull-up enable
  output logic [7:0]         pin_pulldown,     // weak pull-down enable
  output logic [7:0]         pin_analog,       // analog input mode
  output logic [15:0]        pin_drive,        // 2 bits drive per pin
  output logic [7:0]         pin_slew,         // slew control per pin
  output logic [FUNCS-1:0]   periph_in,        // pin data to functions
  output logic [31:0]        status_value,     // chosen status view
  output logic [31:0]        read_value,       // masked pin read
  output logic               port_irq,         // port interrupt, active high
  output gpm_sense_type      sense_readback,   // query_pin sensing
  output gpm_drive_type      drive_readback,   // query_pin drive
  output gpm_pad_type        pad_readback,     // query_pin pad type
  output gpm_dir_type        dir_readback      // query_pin direction
);
  gpm_sense_type sense_q [PIN_COUNT];
  gpm_drive_type drive_q [PIN_COUNT];
  gpm_pad_type   pad_q   [PIN_COUNT];
  gpm_dir_type   dir_q   [PIN_COUNT];
  logic [3:0]    func_q  [PIN_COUNT];
  logic [7:0]    sync1_q, sync2_q;
  logic [7:0]    data_q;
  logic [7:0]    raw_q, raw_d;
  logic [7:0]    en_q;
  logic [7:0]    drv_d, oe_d, pu_d, pd_d, an_d, sl_d;
  logic [15:0]   str_d;
  logic [FUNCS-1:0] pin_in_d;
  gpm_sense_if   sif ();

  gpm_edge_detect u_det (
    .clk     (clk),
    .reset_n (reset_n),
    .sif     (sif)
  );

  // two-stage synchroniser for pad inputs; only the second stage is read
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign sif.level = sync2_q;

  // per-pin configuration storage, stored as written even for inputs
  genvar gi;
  for (gi = 0; gi < PIN_COUNT; gi++)
  begin : g_cfg
    assign sif.sense[gi] = sense_q[gi];
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        sense_q[gi] <= SENSE_RESET;
        drive_q[gi] <= DRIVE_RESET;
        pad_q[gi]   <= PAD_RESET;
        dir_q[gi]   <= DIR_RESET;
        func_q[gi]  <= FUNC_NONE;
      end
      else if (pin_select_mask[gi])
      begin
        if (set_sense)
          sense_q[gi] <= sense_value;
        if (set_pad)
        begin
          drive_q[gi] <= drive_value;
          pad_q[gi]   <= pad_value;
        end
        if (set_dir)
          dir_q[gi] <= dir_value;
        if (set_func)
          func_q[gi] <= func_value;  // one number per pin holds
      end
    end
  end

  // software output data, only selected pins change together
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      data_q <= MASK_RESET;
    else if (write_data)
      data_q <= (data_q & ~pin_select_mask) | (out_value & pin_select_mask);
  end

  // interrupt mask: enable and disable act on selected pins only
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      en_q <= MASK_RESET;
    else if (int_enable)
      en_q <= en_q | pin_select_mask;
    else if (int_disable)
      en_q <= en_q & ~pin_select_mask;
  end

  // raw status: edges stick, levels follow; a new hit beats a clear
  always_comb
  begin
    raw_d = raw_q & ~(int_clear ? pin_select_mask : 8'h00);
    raw_d = raw_d | sif.hit;
    raw_d = (raw_d & ~sif.is_level) | (sif.hit & sif.is_level);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      raw_q <= 8'h00;
    else
      raw_q <= raw_d;
  end

  // pad drive computation per pin
  always_comb
  begin
    drv_d    = 8'h00;
    oe_d     = 8'h00;
    pu_d     = 8'h00;
    pd_d     = 8'h00;
    an_d     = 8'h00;
    sl_d     = 8'h00;
    str_d    = 16'h0000;
    pin_in_d = '0;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      logic od;
      logic drive_en;
      logic val;
      od       = 1'b0;
      drive_en = 1'b0;
      val      = 1'b0;
      if (dir_q[i] == DIR_SW_OUTPUT)
      begin
        drive_en = 1'b1;
        val      = data_q[i];
      end
      else if (dir_q[i] == DIR_PERIPHERAL_OWNED && func_q[i] != FUNC_NONE)
      begin
        drive_en = periph_oe[func_q[i]];
        val      = periph_out[func_q[i]];
        pin_in_d[func_q[i]] = sync2_q[i];
      end
      // pulls apply in every direction, so input pins still see them
      pu_d[i] = (pad_q[i] == PAD_PUSH_PULL_PULLUP) || (pad_q[i] == PAD_OPEN_DRAIN_PULLUP);
      pd_d[i] = (pad_q[i] == PAD_PUSH_PULL_PULLDOWN) || (pad_q[i] == PAD_OPEN_DRAIN_PULLDOWN);
      an_d[i] = (pad_q[i] == PAD_ANALOG);
      od = (pad_q[i] == PAD_OPEN_DRAIN) || (pad_q[i] == PAD_OPEN_DRAIN_PULLUP) ||
           (pad_q[i] == PAD_OPEN_DRAIN_PULLDOWN);
      if (an_d[i])
        drive_en = 1'b0;
      // open drain only pulls low; high is released to the pull or board
      oe_d[i]  = drive_en & (od ? ~val : 1'b1);
      drv_d[i] = od ? 1'b0 : val;
      str_d[2*i +: 2] = drive_en ? drive_q[i] : DRIVE_RESET;
      sl_d[i] = drive_en && (drive_q[i] == DRIVE_EIGHT_MILLIAMP_SLEWED);
    end
  end

  // all outputs registered
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pin_out        <= 8'h00;
      pin_oe         <= 8'h00;
      pin_pullup     <= 8'h00;
      pin_pulldown   <= 8'h00;
      pin_analog     <= 8'h00;
      pin_drive      <= 16'h0000;
      pin_slew       <= 8'h00;
      periph_in      <= '0;
      status_value   <= 32'h00000000;
      read_value     <= 32'h00000000;
      port_irq       <= 1'b0;
      sense_readback <= SENSE_RESET;
      drive_readback <= DRIVE_RESET;
      pad_readback   <= PAD_RESET;
      dir_readback   <= DIR_RESET;
    end
    else
    begin
      pin_out        <= drv_d;
      pin_oe         <= oe_d;
      pin_pullup     <= pu_d;
      pin_pulldown   <= pd_d;
      pin_analog     <= an_d;
      pin_drive      <= str_d;
      pin_slew       <= sl_d;
      periph_in      <= pin_in_d;
      status_value   <= {24'h000000, status_view_select ? (raw_q & en_q) : raw_q};
      read_value     <= {24'h000000, sync2_q & pin_select_mask};
      port_irq       <= |(raw_q & en_q);
      sense_readback <= sense_q[query_pin];
      drive_readback <= drive_q[query_pin];
      pad_readback   <= pad_q[query_pin];
      dir_readback   <= dir_q[query_pin];
    end
  end
endmodule : gpm_port

// ---- test/gpm_board.sv ----
// board model: resolves each pin level from the port drive, pulls and external drivers
`timescale 1ns/1ns
module gpm_board (
  input  wire logic       clk,           // system clock
  input  wire logic [7:0] pin_out,       // port output data
  input  wire logic [7:0] pin_oe,        // port drives the pin
  input  wire logic [7:0] pin_pullup,    // weak pull-up on
  input  wire logic [7:0] pin_pulldown,  // weak pull-down on
  input  wire logic [7:0] ext_en,        // board drives the pin
  input  wire logic [7:0] ext_lv,        // board drive level
  output logic      [7:0] pin_in         // level seen by the port
);
  logic [7:0] flt_q = 8'h55;

  // a floating pin wanders every cycle, so a missing pull never reads as a clean level
  always @(posedge clk)
    flt_q <= ~flt_q;

  // port drive wins, then board drive, then pulls
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lv)
                | (~pin_oe & ~ext_en & (pin_pullup | (~pin_pulldown & flt_q)));
endmodule : gpm_board

// ---- test/gpm_port_monitor.sv ----
// checker: port-level properties of the eight-pin port
`timescale 1ns/1ns
module gpm_port_monitor
  import gpm_pkg::*;
#(
  parameter int unsigned FUNCS = 16  // peripheral functions on the mux
)
(
  input wire logic          clk,                 // system clock
  input wire logic          reset_n,             // sync reset, active low
  input wire logic [7:0]    pin_select_mask,     // command pin mask
  input wire logic          int_disable,         // mask pulse
  input wire logic          int_enable,          // unmask pulse
  input wire logic          status_view_select,  // 1 masked view
  input wire logic [2:0]    query_pin,           // readback pin
  input wire logic [7:0]    pin_oe,              // pad drive enable
  input wire logic [7:0]    pin_pullup,          // pull-up enables
  input wire logic [7:0]    pin_pulldown,        // pull-down enables
  input wire logic [7:0]    pin_analog,          // analog mode
  input wire logic [7:0]    pin_slew,            // slew control
  input wire logic [15:0]   pin_drive,           // 2-bit drive field per pin
  input wire logic [31:0]   status_value,        // status view
  input wire logic [31:0]   read_value,          // masked pin read
  input wire logic          port_irq,            // port interrupt
  input wire gpm_pad_type   pad_readback,        // pad type of query_pin
  input wire gpm_dir_type   dir_readback         // direction of query_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [7:0] slew_field;

  // pins whose drive field holds the slewed 8 mA code; non-driving pins read 2 mA here,
  // while a released open-drain pin keeps its field, so slew there is legal
  genvar gi;
  for (gi = 0; gi < 8; gi++)
  begin : g_slew
    assign slew_field[gi] = (pin_drive[2*gi +: 2] == DRIVE_EIGHT_MILLIAMP_SLEWED);
  end

  a_status_upper_zero: assert property (status_value[31:8] == 24'h000000)
    else $error("status upper bits set");
  a_read_upper_zero: assert property (read_value[31:8] == 24'h000000)
    else $error("read upper bits set");
  a_read_unselected_zero: assert property ((read_value[7:0] & ~$past(pin_select_mask)) == 8'h00)
    else $error("unselected pin read nonzero");
  a_analog_no_drive: assert property ((pin_analog & pin_oe) == 8'h00)
    else $error("analog pin driven");
  a_pull_one_way: assert property ((pin_pullup & pin_pulldown) == 8'h00)
    else $error("pull-up and pull-down together");
  a_slew_idle_pin: assert property ((pin_slew & (~slew_field | pin_analog)) == 8'h00)
    else $error("slew without slewed drive");
  a_input_not_driven: assert property (dir_readback == DIR_SW_INPUT |-> !pin_oe[$past(query_pin)])
    else $error("input pin driven");
  a_analog_readback: assert property (pad_readback == PAD_ANALOG |-> pin_analog[$past(query_pin)])
    else $error("analog type without analog mode");
  a_disable_quiet: assert property ((int_disable && !int_enable && pin_select_mask == 8'hFF)
    ##1 !int_enable |=> !port_irq) else $error("irq after full disable");
  a_irq_masked_view: assert property ($past(status_view_select) |-> port_irq == (status_value[7:0] != 8'h00))
    else $error("irq differs from masked status");

  c_irq: cover property (port_irq);
  c_analog: cover property (pad_readback == PAD_ANALOG);
  c_disable_all: cover property (int_disable && pin_select_mask == 8'hFF);
endmodule : gpm_port_monitor

bind gpm_port gpm_port_monitor #(.FUNCS(FUNCS)) mon (.*);

// ---- test/gpm_port_tb.sv ----
// testbench: command sequences against the eight-pin port
`timescale 1ns/1ns
module gpm_port_tb;
  import gpm_pkg::*;
  localparam int SNS = 0, PAD = 1, DIR = 2, FNC = 3, WR = 4, CLR = 5, DIS = 6, ENA = 7;
  logic          clk = 1'b0;
  logic          reset_n = 1'b0;
  logic [7:0]    pin_select_mask = 8'h00, pulse = 8'h00, out_value = 8'h00, ext_en = 8'h00, ext_lv = 8'h00;
  logic [7:0]    pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, pin_analog, pin_slew;
  logic [15:0]   periph_out = 16'h0000, periph_oe = 16'h0000, periph_in, pin_drive;
  logic [31:0]   status_value, read_value;
  logic [3:0]    func_value = 4'h0;
  logic [2:0]    query_pin = 3'h0;
  logic          status_view_select = 1'b0, port_irq;
  gpm_sense_type sense_value = SENSE_FALLING, sense_readback;
  gpm_drive_type drive_value = DRIVE_TWO_MILLIAMP, drive_readback;
  gpm_pad_type   pad_value = PAD_PUSH_PULL, pad_readback;
  gpm_dir_type   dir_value = DIR_SW_INPUT, dir_readback;
  int            errors = 0, n_tests = 0, cyc = 0;

  gpm_port uut (.*, .set_sense(pulse[SNS]), .set_pad(pulse[PAD]), .set_dir(pulse[DIR]), .set_func(pulse[FNC]),
    .write_data(pulse[WR]), .int_clear(pulse[CLR]), .int_disable(pulse[DIS]), .int_enable(pulse[ENA]));
  gpm_board board (.*);

  always #50 clk = ~clk;

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic go(input int n);
    repeat (n) @(negedge clk);
  endtask : go

  // one command pulse, then time for the stored value to reach the outputs
  task automatic cmd(input int k, input logic [7:0] m);
    pin_select_mask = m;
    pulse = 8'h01 << k;
    go(1);
    pulse = 8'h00;
    go(2);
  endtask : cmd

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      stop_test();
    end
  end

  // main sequence, inputs change on the falling edge
  initial
  begin
    go(4);
    reset_n = 1'b1;
    go(1);
    chk(sense_readback, SENSE_FALLING);
    chk(drive_readback, DRIVE_TWO_MILLIAMP);
    chk(dir_readback, DIR_SW_INPUT);
    $display("reset test done");
    for (int p = 0; p < 7; p++)
    begin
      pad_value = gpm_pad_type'(p);
      drive_value = gpm_drive_type'(p % 4);
      cmd(PAD, 8'h01);
      chk(pad_readback, p);
      chk(drive_readback, p % 4);
      chk(pin_pullup, (p == 1 || p == 4) ? 8'h01 : 8'h00);
      chk(pin_pulldown, (p == 2 || p == 5) ? 8'h01 : 8'h00);
      chk(pin_analog, (p == 6) ? 8'h01 : 8'h00);
      chk({pin_oe, pin_slew, pin_drive[1:0]}, 0);
    end
    query_pin = 3'h3;
    go(2);
    chk(pad_readback, PAD_PUSH_PULL);
    $display("pad test done");
    query_pin = 3'h1;
    dir_value = DIR_SW_OUTPUT;
    cmd(DIR, 8'h02);
    pad_value = PAD_PUSH_PULL;
    drive_value = DRIVE_EIGHT_MILLIAMP_SLEWED;
    cmd(PAD, 8'h02);
    out_value = 8'h02;
    cmd(WR, 8'h02);
    chk(dir_readback, DIR_SW_OUTPUT);
    chk({pin_oe[1], pin_out[1], pin_slew[1], pin_drive[3:2]}, 5'h1F);
    pad_value = PAD_OPEN_DRAIN;
    drive_value = DRIVE_FOUR_MILLIAMP;
    cmd(PAD, 8'h02);
    chk(pin_oe[1], 1'b0);
    out_value = 8'h00;
    cmd(WR, 8'h02);
    chk({pin_oe[1], pin_out[1], pin_drive[3:2]}, {2'b10, DRIVE_FOUR_MILLIAMP});
    pad_value = PAD_OPEN_DRAIN_PULLUP;
    cmd(PAD, 8'h02);
    out_value = 8'h02;
    cmd(WR, 8'h02);
    go(3);
    chk(read_value, 32'h2);
    pin_select_mask = 8'h00;
    go(2);
    chk(read_value, 32'h0);
    $display("output test done");
    func_value = 4'h5;
    cmd(FNC, 8'h04);
    dir_value = DIR_PERIPHERAL_OWNED;
    cmd(DIR, 8'h04);
    periph_out = 16'h0020;
    periph_oe = 16'h0020;
    go(4);
    chk({pin_oe[2], pin_out[2], periph_in[5]}, 3'b111);
    func_value = 4'h6;
    cmd(FNC, 8'h04);
    go(3);
    chk({pin_oe[2], periph_in[5]}, 2'b00);
    $display("mux test done");
    // every pin gets a board level, so floating pins raise no stray events in the raw view
    ext_en = 8'hFF;
    query_pin = 3'h4;
    cmd(ENA, 8'h10);
    cmd(CLR, 8'hFF);
    for (int s = 0; s < 5; s++)
    begin
      ext_lv[4] = (s == 0 || s == 3);
      go(4);
      sense_value = gpm_sense_type'(s);
      cmd(SNS, 8'h10);
      chk(sense_readback, s);
      cmd(CLR, 8'h10);
      go(2);
      chk(status_value, 32'h0);
      ext_lv[4] = !ext_lv[4];
      go(6);
      chk({status_value, port_irq}, {32'h10, 1'b1});
      cmd(CLR, 8'h10);
      go(2);
      chk(status_value, (s > 2) ? 32'h10 : 32'h0);
    end
    ext_lv[4] = 1'b0;
    go(4);
    sense_value = SENSE_RISING;
    cmd(SNS, 8'h10);
    cmd(CLR, 8'h10);
    ext_lv[4] = 1'b1;
    go(6);
    cmd(CLR, 8'hEF);
    chk(status_value, 32'h10);
    status_view_select = 1'b1;
    cmd(DIS, 8'hFF);
    chk({status_value, port_irq}, 0);
    status_view_select = 1'b0;
    go(2);
    chk(status_value, 32'h10);
    status_view_select = 1'b1;
    cmd(ENA, 8'h10);
    chk({status_value, port_irq}, {32'h10, 1'b1});
    $display("interrupt test done");
    stop_test();
  end
endmodule : gpm_port_tb
